// ---- core/tpio_pin_unit.sv ----
// One timer pin: output compare and input capture driven by its 4-bit select field
`timescale 1ns/1ps
module tpio_pin_unit
  import tpio_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] sel_i,        // Select field, bits 7..4 of the control register
  input wire logic sel_wr_i,           // Pulse: control register written
  input wire logic disable_i,          // Buffer mode kills this function
  input wire logic [W-1:0] count_i,    // Channel counter
  input wire logic [W-1:0] gen_reg_i,  // General register value for compare
  input wire logic pin_i,              // Synchronised pin level
  output logic pin_o,                  // Pin drive level
  output logic pin_oe_o,               // High while the unit drives the pin
  output logic match_o,                // Compare match pulse
  output logic capture_o               // Capture request pulse
);
  logic pin_q;        // Previous synchronised pin level for edge detection
  logic matched;      // Counter equals register, level
  logic match_q;      // Last cycle's equality, for a one-pulse match
  logic is_capture;   // Top field bit selects input capture
  logic rise;         // Rising edge on pin
  logic fall;         // Falling edge on pin
  logic next_pin;     // Next drive level

  assign is_capture = sel_i[3];
  assign matched = (count_i == gen_reg_i);
  assign rise = pin_i && !pin_q;
  assign fall = !pin_i && pin_q;

  // One pulse per equality period, so a stopped counter does not re-fire
  assign match_o = !is_capture && !disable_i && matched && !match_q;

  // Edge choice: bit 5 picks both edges, else bit 4 picks falling over rising
  always_comb begin
    capture_o = 1'b0;
    if (is_capture && !disable_i) begin
      if (sel_i[1]) begin
        capture_o = rise || fall;
      end else if (sel_i[0]) begin
        capture_o = fall;
      end else begin
        capture_o = rise;
      end
    end
  end

  // Drive level: initial on write, action on match, otherwise held
  always_comb begin
    next_pin = pin_o;
    if (sel_wr_i && !is_capture && sel_i[1:0] != ACT_HOLD) begin
      next_pin = sel_i[2];
    end else if (match_o) begin
      case (tpio_act_t'(sel_i[1:0]))
        ACT_LOW: next_pin = 1'b0;
        ACT_HIGH: next_pin = 1'b1;
        ACT_TOGGLE: next_pin = !pin_o;
        default: next_pin = pin_o;
      endcase
    end
  end

  // Pin level starts low at reset and stays until programmed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      pin_o <= next_pin;
      pin_q <= pin_i;
      match_q <= matched;
    end
  end

  // Output compare drives the pin, capture releases it
  assign pin_oe_o = !is_capture && !disable_i;
endmodule // tpio_pin_unit

// ---- core/tpio_pkg.sv ----
// Package: register map, field layout and mode codes for the timer pin I/O block
package tpio_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CH3_LOW_PIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_CH4_HIGH_PIN_CTRL = 8'h04;
  localparam logic [7:0] OFS_CH4_LOW_PIN_CTRL = 8'h08;
  localparam logic [7:0] OFS_CH3_MODE_REG = 8'h0c;
  localparam logic [7:0] OFS_CH3_COUNTER = 8'h10;
  localparam logic [7:0] OFS_CH3_GENERAL_REG_D = 8'h14;
  localparam logic [7:0] OFS_CH4_COUNTER = 8'h18;
  localparam logic [7:0] OFS_CH4_GENERAL_REG_B = 8'h1c;
  localparam logic [7:0] OFS_CH4_GENERAL_REG_D = 8'h20;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h24;
  // Field positions: the 4-bit select field sits in bits 7..4
  localparam int FLD_LSB = 4;
  localparam int FLD_MSB = 7;
  localparam int BUFFER_MODE_B_BIT = 5;
  localparam int CNT_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_REG_RST = 8'h00;
  localparam logic [15:0] GEN_REG_RST = 16'hffff;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Compare-match pin actions from the low two field bits
  typedef enum logic [1:0] {
    ACT_HOLD = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tpio_act_t;
endpackage

// ---- core/tpio_top.sv ----
// Top: AXI4-Lite registers, two channel counters and three timer pin units
`timescale 1ns/1ps
module tpio_top
  import tpio_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Timer pins
  input wire logic CH3_PIN_D_I,
  output logic CH3_PIN_D_O,
  output logic CH3_PIN_D_OE_O,
  input wire logic CH4_PIN_B_I,
  output logic CH4_PIN_B_O,
  output logic CH4_PIN_B_OE_O,
  input wire logic CH4_PIN_D_I,
  output logic CH4_PIN_D_O,
  output logic CH4_PIN_D_OE_O
);
  import tpio_pkg::*;

  // Control registers
  logic [7:0] ch3_low_pin_ctrl;   // Channel 3 pin D select
  logic [7:0] ch4_high_pin_ctrl;  // Channel 4 pin B select
  logic [7:0] ch4_low_pin_ctrl;   // Channel 4 pin D select
  logic [7:0] ch3_mode_reg;       // Channel 3 mode: buffer mode and count enable
  logic [7:0] ch4_mode_reg;       // Channel 4 count enable only, not on the bus map
  logic [W-1:0] ch3_counter;      // Channel 3 free-running counter
  logic [W-1:0] ch4_counter;      // Channel 4 free-running counter
  // General registers: compare value, or the count taken at a capture edge
  logic [W-1:0] ch3_general_reg_d; // Channel 3 register D
  logic [W-1:0] ch4_general_reg_b; // Channel 4 register B
  logic [W-1:0] ch4_general_reg_d; // Channel 4 register D

  // Pin synchronisers: first stage read only by second stage
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // Write path state
  logic [7:0] aw_addr;   // Latched write address
  logic aw_held;         // Address taken, waiting for data
  logic [31:0] w_data;   // Latched write data
  logic [3:0] w_strb;    // Latched byte enables
  logic w_held;          // Data taken, waiting for address
  logic wr_fire;         // Both halves present: perform write this cycle
  logic wr_hit;          // Write address decodes to a register
  logic [2:0] sel_wr;    // Per-pin control write pulses
  logic [2:0] sel_wr_q;  // Same pulses one cycle late, once the field holds the new code

  // Unit outputs; match pulses stay inside the units, the pins show their effect
  logic [2:0] capture;
  logic ch3_d_off;       // Buffer mode on channel 3 register D

  // Two-flop synchroniser on all three pins
  // Reset to the low drive level, so the edge detectors see no false edge after reset
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {CH4_PIN_D_I, CH4_PIN_B_I, CH3_PIN_D_I};
      pin_sync <= pin_meta;
    end
  end

  // Address and data are accepted independently, one write at a time
  // Readies are combinational so a request is taken in the cycle it appears
  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held && !S_AXI_BVALID_O;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID_O;

  // Hold write address and data until both have arrived
  // A half that arrives early waits here for its partner; either may come first
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Decode of writable offsets
  // Read-only counters and status fall through and answer SLVERR
  always_comb begin
    wr_hit = 1'b0;
    sel_wr = 3'h0;
    if (aw_addr == OFS_CH3_LOW_PIN_CTRL) begin
      wr_hit = 1'b1;
      sel_wr[0] = wr_fire && w_strb[0];
    end else if (aw_addr == OFS_CH4_HIGH_PIN_CTRL) begin
      wr_hit = 1'b1;
      sel_wr[1] = wr_fire && w_strb[0];
    end else if (aw_addr == OFS_CH4_LOW_PIN_CTRL) begin
      wr_hit = 1'b1;
      sel_wr[2] = wr_fire && w_strb[0];
    end else if (aw_addr == OFS_CH3_MODE_REG || aw_addr == OFS_CH3_GENERAL_REG_D) begin
      // Mode and general registers load in their own processes below
      wr_hit = 1'b1;
    end else if (aw_addr == OFS_CH4_GENERAL_REG_B || aw_addr == OFS_CH4_GENERAL_REG_D) begin
      wr_hit = 1'b1;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  // BVALID stands until the master takes it; a new write waits for that edge
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Pin control and mode registers, low byte lane only
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ch3_low_pin_ctrl <= PIN_CTRL_RST;
      ch4_high_pin_ctrl <= PIN_CTRL_RST;
      ch4_low_pin_ctrl <= PIN_CTRL_RST;
      ch3_mode_reg <= MODE_REG_RST;
      ch4_mode_reg <= MODE_REG_RST;
    end else begin
      // Only the low byte lane carries the 8-bit fields
      if (sel_wr[0]) begin
        ch3_low_pin_ctrl <= w_data[7:0];
      end
      if (sel_wr[1]) begin
        ch4_high_pin_ctrl <= w_data[7:0];
      end
      if (sel_wr[2]) begin
        ch4_low_pin_ctrl <= w_data[7:0];
      end
      // Mode register: bit 5 buffer mode, bit 0 count enable
      if (wr_fire && w_strb[0] && aw_addr == OFS_CH3_MODE_REG) begin
        ch3_mode_reg <= w_data[7:0];
      end
      // Channel 4 follows the channel 3 enable one cycle later; kept simple on purpose
      ch4_mode_reg <= ch3_mode_reg;
    end
  end

  // Counters advance when enabled; no prescaler in this block
  // They wrap at the top of the range; software reads them live
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ch3_counter <= COUNTER_RST[W-1:0];
      ch4_counter <= COUNTER_RST[W-1:0];
    end else begin
      if (ch3_mode_reg[CNT_EN_BIT]) begin
        ch3_counter <= ch3_counter + 1'b1;
      end
      if (ch4_mode_reg[CNT_EN_BIT]) begin
        ch4_counter <= ch4_counter + 1'b1;
      end
    end
  end

  // General registers: capture beats a software write in the same cycle
  // A write that loses to a capture is dropped, so software should read back
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ch3_general_reg_d <= GEN_REG_RST[W-1:0];
      ch4_general_reg_b <= GEN_REG_RST[W-1:0];
      ch4_general_reg_d <= GEN_REG_RST[W-1:0];
    end else begin
      if (capture[0]) begin
        ch3_general_reg_d <= ch3_counter;
      end else if (wr_fire && aw_addr == OFS_CH3_GENERAL_REG_D) begin
        ch3_general_reg_d <= w_data[W-1:0];
      end
      if (capture[1]) begin
        ch4_general_reg_b <= ch4_counter;
      end else if (wr_fire && aw_addr == OFS_CH4_GENERAL_REG_B) begin
        ch4_general_reg_b <= w_data[W-1:0];
      end
      if (capture[2]) begin
        ch4_general_reg_d <= ch4_counter;
      end else if (wr_fire && aw_addr == OFS_CH4_GENERAL_REG_D) begin
        ch4_general_reg_d <= w_data[W-1:0];
      end
    end
  end

  // Initial level waits one cycle after the write, until the unit's select field holds
  // the new code; in the write cycle itself the field still shows the old one
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_wr_q <= 3'h0;
    end else begin
      sel_wr_q <= sel_wr;
    end
  end

  // Buffer mode turns the channel 3 pin D function off entirely
  // The stored field survives, so clearing buffer mode restores the pin function
  assign ch3_d_off = ch3_mode_reg[BUFFER_MODE_B_BIT];

  // Channel 3 pin D: the only unit that buffer mode can switch off
  tpio_pin_unit #(.W(W)) u_ch3_pin_d (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .sel_i(ch3_low_pin_ctrl[FLD_MSB:FLD_LSB]),
    .sel_wr_i(sel_wr_q[0] && !ch3_d_off),
    .disable_i(ch3_d_off),
    .count_i(ch3_counter),
    .gen_reg_i(ch3_general_reg_d),
    .pin_i(pin_sync[0]),
    .pin_o(CH3_PIN_D_O),
    .pin_oe_o(CH3_PIN_D_OE_O),
    .match_o(),
    .capture_o(capture[0])
  );

  // Channel 4 pin B, compared against general register B
  tpio_pin_unit #(.W(W)) u_ch4_pin_b (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .sel_i(ch4_high_pin_ctrl[FLD_MSB:FLD_LSB]),
    .sel_wr_i(sel_wr_q[1]),
    .disable_i(1'b0),
    .count_i(ch4_counter),
    .gen_reg_i(ch4_general_reg_b),
    .pin_i(pin_sync[1]),
    .pin_o(CH4_PIN_B_O),
    .pin_oe_o(CH4_PIN_B_OE_O),
    .match_o(),
    .capture_o(capture[1])
  );

  // Channel 4 pin D, compared against general register D
  tpio_pin_unit #(.W(W)) u_ch4_pin_d (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .sel_i(ch4_low_pin_ctrl[FLD_MSB:FLD_LSB]),
    .sel_wr_i(sel_wr_q[2]),
    .disable_i(1'b0),
    .count_i(ch4_counter),
    .gen_reg_i(ch4_general_reg_d),
    .pin_i(pin_sync[2]),
    .pin_o(CH4_PIN_D_O),
    .pin_oe_o(CH4_PIN_D_OE_O),
    .match_o(),
    .capture_o(capture[2])
  );

  // Read channel: one read at a time, answer one cycle after the address
  // Unmapped offsets read zero with SLVERR; unused upper bits always read zero
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= RESP_OKAY;
      S_AXI_RDATA_O <= 32'h0000_0000;
      // Byte-wide control and mode registers use the low lane
      if (S_AXI_ARADDR_I == OFS_CH3_LOW_PIN_CTRL) begin
        S_AXI_RDATA_O[7:0] <= ch3_low_pin_ctrl;
      end else if (S_AXI_ARADDR_I == OFS_CH4_HIGH_PIN_CTRL) begin
        S_AXI_RDATA_O[7:0] <= ch4_high_pin_ctrl;
      end else if (S_AXI_ARADDR_I == OFS_CH4_LOW_PIN_CTRL) begin
        S_AXI_RDATA_O[7:0] <= ch4_low_pin_ctrl;
      end else if (S_AXI_ARADDR_I == OFS_CH3_MODE_REG) begin
        S_AXI_RDATA_O[7:0] <= ch3_mode_reg;
      end else if (S_AXI_ARADDR_I == OFS_CH3_COUNTER) begin
        // Counters and general registers fill the low half-word
        S_AXI_RDATA_O[W-1:0] <= ch3_counter;
      end else if (S_AXI_ARADDR_I == OFS_CH3_GENERAL_REG_D) begin
        S_AXI_RDATA_O[W-1:0] <= ch3_general_reg_d;
      end else if (S_AXI_ARADDR_I == OFS_CH4_COUNTER) begin
        S_AXI_RDATA_O[W-1:0] <= ch4_counter;
      end else if (S_AXI_ARADDR_I == OFS_CH4_GENERAL_REG_B) begin
        S_AXI_RDATA_O[W-1:0] <= ch4_general_reg_b;
      end else if (S_AXI_ARADDR_I == OFS_CH4_GENERAL_REG_D) begin
        S_AXI_RDATA_O[W-1:0] <= ch4_general_reg_d;
      end else if (S_AXI_ARADDR_I == OFS_PIN_STATUS) begin
        // Live pin drive levels and synchronised inputs
        S_AXI_RDATA_O[5:0] <= {pin_sync, CH4_PIN_D_O, CH4_PIN_B_O, CH3_PIN_D_O};
      end else begin
        S_AXI_RRESP_O <= RESP_SLVERR;
      end
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
endmodule // tpio_top

// ---- verification/tb_timer_pin_io_mode_select.sv ----
// Testbench for the timer pin mode block, driven over its register bus
`timescale 1ns/1ps
module tb_timer_pin_io_mode_select;
  import tpio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf; // Whole words only
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] po, poe, pin; // Pins: 0 ch3 D, 1 ch4 B, 2 ch4 D
  logic [2:0] lvl = 3'b010; // Outside levels
  logic [7:0] ctl [3] = '{OFS_CH3_LOW_PIN_CTRL, OFS_CH4_HIGH_PIN_CTRL, OFS_CH4_LOW_PIN_CTRL};
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  tpio_top DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .CH3_PIN_D_I(pin[0]), .CH3_PIN_D_O(po[0]), .CH3_PIN_D_OE_O(poe[0]),
    .CH4_PIN_B_I(pin[1]), .CH4_PIN_B_O(po[1]), .CH4_PIN_B_OE_O(poe[1]),
    .CH4_PIN_D_I(pin[2]), .CH4_PIN_D_O(po[2]), .CH4_PIN_D_OE_O(poe[2]));
  tpio_pin_model u_pins (.o_i(po), .oe_i(poe), .lvl_i(lvl), .pin_o(pin));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bus write: each half released once taken, ready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) n_fail++;
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) n_fail++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Write expecting a good response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", r, RESP_OKAY);
  endtask
  // Pins low and driven after reset; pin B control and general register B at their reset values
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk("pins", po, 3'b000);
    chk("oe", poe, 3'b111);
    axi_rd(OFS_CH4_HIGH_PIN_CTRL, d, r);
    chk("ctrl", d, PIN_CTRL_RST);
    axi_rd(OFS_CH4_GENERAL_REG_B, d, r);
    chk("gen", d, GEN_REG_RST);
    $display("test reset done");
  endtask
  // Every compare code on every pin; hold codes keep the level
  task automatic t_init();
    logic [2:0] e = 3'b000;
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 8; c++) begin
        wr(ctl[i], {24'h0, 1'b0, c[2:0], 4'h0});
        if (c[1:0] != 2'b00) e[i] = c[2];
        @(posedge clk);
        chk("init", po[i], e[i]);
      end
    end
    $display("test init done");
  endtask
  // One match each for toggle, low, high and hold on pin B
  task automatic t_match();
    logic [31:0] codes = 32'h40205030;
    logic [3:0] ini = 4'b1010;
    logic [3:0] fin = 4'b1101;
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      axi_rd(OFS_CH4_COUNTER, d, r);
      wr(OFS_CH4_GENERAL_REG_B, d + 32'h8);
      wr(OFS_CH4_HIGH_PIN_CTRL, {24'h0, codes[8*k+:8]});
      @(posedge clk);
      chk("before", po[1], ini[k]);
      wr(OFS_CH3_MODE_REG, 32'h1);
      repeat (20) @(posedge clk);
      wr(OFS_CH3_MODE_REG, 32'h0);
      chk("match", po[1], fin[k]);
    end
    $display("test match done");
  endtask
  // Capture edges: rising, falling with bit 6 set, both, both with bit 4 set
  task automatic t_cap();
    logic [31:0] codes = 32'hb0a0d080;
    logic [7:0] capx = 8'b1111_0110; // Index 2k for falling, 2k+1 for rising
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_CH3_MODE_REG, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CH4_HIGH_PIN_CTRL, {24'h0, codes[8*k+:8]});
      for (int e = 0; e < 2; e++) begin
        wr(OFS_CH4_GENERAL_REG_B, 32'h0);
        lvl[1] <= e[0];
        repeat (8) @(posedge clk);
        axi_rd(OFS_CH4_GENERAL_REG_B, d, r);
        chk("cap", d != 0, capx[2*k+e]);
      end
    end
    $display("test capture done");
  endtask
  // Buffer mode silences ch3 pin D, then releasing it restores capture
  task automatic t_buf();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_CH3_MODE_REG, 32'h21);
    wr(OFS_CH3_LOW_PIN_CTRL, 32'h30);
    chk("oe", poe[0], 1'b0);
    wr(OFS_CH3_LOW_PIN_CTRL, 32'ha0);
    for (int b = 1; b >= 0; b--) begin
      wr(OFS_CH3_MODE_REG, {26'h0, b[0], 5'h1});
      wr(OFS_CH3_GENERAL_REG_D, 32'h0);
      lvl[0] <= ~lvl[0];
      repeat (8) @(posedge clk);
      axi_rd(OFS_CH3_GENERAL_REG_D, d, r);
      chk("bufcap", d != 0, !b[0]);
    end
    $display("test buffer done");
  endtask
  // Unmapped access is refused and leaves the pin B control register alone
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h40, 32'h1, r);
    chk("bresp", r, RESP_SLVERR);
    axi_rd(8'h40, d, r);
    chk("rresp", r, RESP_SLVERR);
    chk("rdata", d, 32'h0);
    axi_rd(OFS_CH4_HIGH_PIN_CTRL, d, r);
    chk("ctrl", d, 32'hb0);
    $display("test unmapped done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_init();
    t_match();
    t_cap();
    t_buf();
    t_unmapped();
    test_done();
  end
  // Run takes a few hundred cycles; cut a hang well beyond that
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule // tb_timer_pin_io_mode_select
bind tpio_top tpio_chk u_chk (.*);

// ---- verification/tpio_chk.sv ----
// Checker for the timer pin block: pin levels and bus answers over time
`timescale 1ns/1ps
module tpio_chk
  import tpio_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic CH3_PIN_D_OE_O,
  input wire logic CH4_PIN_B_O,
  input wire logic CH4_PIN_B_OE_O,
  input wire logic CH4_PIN_D_O
);
  logic [7:0] aw_q; // Last write address taken
  logic [7:0] wd_q; // Low byte of last write data taken
  logic bv_q; // Response valid one cycle ago
  logic [7:0] ctrl_b; // Pin B control as written, one cycle late
  logic [7:0] mode_q; // Mode register as written, one cycle late
  logic bv_rise; // First cycle of a write response
  logic wr_ok; // First cycle of a good write response
  assign bv_rise = S_AXI_BVALID_O && !bv_q;
  assign wr_ok = bv_rise && S_AXI_BRESP_O == RESP_OKAY;
  // Shadows lag the design by one cycle, so checks skip cycles with a response up
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      bv_q <= 1'b0;
      ctrl_b <= PIN_CTRL_RST;
      mode_q <= MODE_REG_RST;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) aw_q <= S_AXI_AWADDR_I;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) wd_q <= S_AXI_WDATA_I[7:0];
      bv_q <= S_AXI_BVALID_O;
      if (wr_ok && aw_q == OFS_CH4_HIGH_PIN_CTRL) ctrl_b <= wd_q;
      if (wr_ok && aw_q == OFS_CH3_MODE_REG) mode_q <= wd_q;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_rst_low; $rose(RST_N_I) |-> !CH4_PIN_B_O && !CH4_PIN_D_O; endproperty
  a_rst_low: assert property (p_rst_low) else $error("pin high after reset");
  // The initial level lands one edge after the write response rises
  property p_init_b;
    wr_ok && aw_q == OFS_CH4_HIGH_PIN_CTRL && !wd_q[7] && wd_q[5:4] != 2'b00
      |=> CH4_PIN_B_O == wd_q[6];
  endproperty
  a_init_b: assert property (p_init_b) else $error("pin B initial level");
  property p_init_d;
    wr_ok && aw_q == OFS_CH4_LOW_PIN_CTRL && !wd_q[7] && wd_q[5:4] != 2'b00
      |=> CH4_PIN_D_O == wd_q[6];
  endproperty
  a_init_d: assert property (p_init_d) else $error("pin D initial level");
  property p_hold;
    (!ctrl_b[7] && ctrl_b[5:4] == 2'b00 && !S_AXI_BVALID_O) [*2] |-> $stable(CH4_PIN_B_O);
  endproperty
  a_hold: assert property (p_hold) else $error("pin B moved in hold");
  property p_oe_b; !S_AXI_BVALID_O |-> CH4_PIN_B_OE_O == !ctrl_b[7]; endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B drive enable");
  property p_buf; mode_q[BUFFER_MODE_B_BIT] && !S_AXI_BVALID_O |-> !CH3_PIN_D_OE_O; endproperty
  a_buf: assert property (p_buf) else $error("ch3 D driven in buffer mode");
  property p_slverr; bv_rise && aw_q > OFS_PIN_STATUS |-> S_AXI_BRESP_O == RESP_SLVERR; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
  property p_b_lat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |-> ##2 S_AXI_BVALID_O;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_b_drop; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response stuck");
  property p_aw_block; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  c_slverr: cover property (bv_rise && S_AXI_BRESP_O == RESP_SLVERR);
  c_capture: cover property (!CH4_PIN_B_OE_O);
  c_buffer: cover property (mode_q[BUFFER_MODE_B_BIT]);
endmodule // tpio_chk

// ---- verification/tpio_pin_model.sv ----
// Far side: outside signals on the three timer pins
`timescale 1ns/1ps
module tpio_pin_model #(
  parameter int DLY = 3
) (
  input wire logic [2:0] o_i, // Device drive levels
  input wire logic [2:0] oe_i, // Device drive enables
  input wire logic [2:0] lvl_i, // Level the outside source wants
  output wire logic [2:0] pin_o // Wire level fed back to the device
);
  // A driven pin reads back the device; the delay keeps outside edges off the clock edge
  assign #DLY pin_o = (oe_i & o_i) | (~oe_i & lvl_i);
endmodule // tpio_pin_model
